// ---- logic/icd_top.sv ----
// Command/data port and standard-speed SCL timing of the I2C controller.
//
// What this block does
// [RULE1] Master: direction 0 writes, 1 reads.
// [RULE2] Direction bit ignored for slave direction.
// [RULE3] Slave receiver ignores the direction bit.
// [RULE4] Slave transmitter sends byte of write entry.
// [RULE5] Read after general call aborts unless flag clear.
// [RULE6] Read direction after read request aborts.
// [RULE7] Read command ignores written byte field.
// [RULE8] Port read returns the received byte.
// [RULE9] Software programs counts before any transfer.
// [RULE10] Sixteen-bit high count, reset 0x0028.
// [RULE11] Sixteen-bit low count, reset 0x002F.
// [RULE12] Count writes only while controller disabled.
// [RULE13] High count below six stores six.
// [RULE14] Low count below eight stores eight.
// [RULE15] Idle flagged at high count plus ten.
// [RULE16] Narrow bus writes low byte first; here the port is 32 bits wide and takes each count in one write.
// [RULE17] Phases measured in controller clock cycles.
module icd_top (
  input  wire logic                 mclk,              // Controller clock.
  input  wire logic                 resetn,            // Async reset.
  input  wire logic                 ce,                // Clock enable.
  input  wire logic                 reg_wr,            // Register write.
  input  wire logic                 reg_rd,            // Register read.
  input  wire logic [7:0]           reg_addr,          // Byte address.
  input  wire logic [31:0]          reg_wdata,         // Write data.
  output logic      [31:0]          reg_rdata,         // Read data.
  input  wire logic                 controller_enable, // Enable bit 0.
  input  wire logic                 master_mode,       // Acting as master.
  input  wire logic                 slave_tx_mode,     // Slave transmitter.
  input  wire logic                 general_call_sent, // General call done.
  input  wire logic                 command_flag_a,    // Target bit 11.
  input  wire logic                 rd_req_seen,       // Read request seen.
  input  wire logic                 rx_valid,          // Byte received.
  input  wire logic [7:0]           rx_byte,           // Received byte.
  input  wire logic                 scl_run,           // Engine wants SCL.
  input  wire logic                 scl_in,            // SCL pin level.
  input  wire logic                 sda_in,            // SDA pin level.
  output logic                      scl_out,           // SCL output level.
  output logic                      scl_oe,            // SCL pulled low.
  output logic                      bus_idle,          // Bus idle flag.
  output logic                      cmd_valid,         // Entry pushed.
  output icd_pkg::icd_cmd_t         cmd_entry,         // Pushed entry.
  output logic                      transmit_abort_event, // Abort pulse.
  output logic                      rx_pop             // Received byte read.
);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  logic [15:0] std_scl_high_count; // Programmed high count.
  logic [15:0] std_scl_low_count;  // Programmed low count.
  logic [7:0]  rx_hold;            // Last byte received from the bus.

  wire sel_cmd  = reg_addr == icd_pkg::CMD_DATA_OFFSET;
  wire sel_high = reg_addr == icd_pkg::SCL_HIGH_OFFSET;
  wire sel_low  = reg_addr == icd_pkg::SCL_LOW_OFFSET;
  wire wr_cmd   = reg_wr && sel_cmd;
  // Count writes pass only while the controller is off.
  // [RULE12] enable gates writes
  wire wr_high  = reg_wr && sel_high && !controller_enable;
  wire wr_low   = reg_wr && sel_low && !controller_enable;

  wire [15:0] wr_count = reg_wdata[icd_pkg::COUNT_W-1:0];
  // [RULE13] clamp high count
  wire [15:0] next_high = (wr_count < icd_pkg::SCL_HIGH_MIN) ?
                          icd_pkg::SCL_HIGH_MIN : wr_count;
  // [RULE14] clamp low count
  wire [15:0] next_low  = (wr_count < icd_pkg::SCL_LOW_MIN) ?
                          icd_pkg::SCL_LOW_MIN : wr_count;

  // Read mux; unmapped addresses read zero, reserved bits read zero.
  // [RULE8] received byte readback
  wire [31:0] next_rdata = sel_cmd  ? {24'h000000, rx_hold} :
                           sel_high ? {16'h0000, std_scl_high_count} :
                           sel_low  ? {16'h0000, std_scl_low_count} :
                           32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Command classification.
  wire wr_dir = reg_wdata[icd_pkg::DIR_BIT];
  // Entry direction follows the bit only as master; as slave only write entries count.
  // [RULE1] master direction select
  // [RULE2] slave ignores direction
  wire is_read = master_mode && (wr_dir == icd_pkg::DIR_READ);
  // [RULE5] general call read abort
  wire abort_gc = master_mode && is_read && general_call_sent &&
                  command_flag_a;
  // [RULE6] read direction after request
  wire abort_rq = !master_mode && slave_tx_mode && rd_req_seen &&
                  (wr_dir == icd_pkg::DIR_READ);
  wire do_abort = wr_cmd && (abort_gc || abort_rq);
  // Slave receiver takes no entries, so its writes are dropped outright.
  // [RULE3] slave receiver ignores writes
  // [RULE4] slave transmit byte
  wire do_push  = wr_cmd && !do_abort && (master_mode || slave_tx_mode);
  // [RULE7] read drops byte field
  wire [7:0] push_byte = is_read ? 8'h00 :
                         reg_wdata[icd_pkg::BYTE_LSB +: icd_pkg::BYTE_W];

  ////////////////////////////////////////////////////////////////////////////
  // Register file and command strobe.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // [RULE10] high count reset
      std_scl_high_count   <= icd_pkg::SCL_HIGH_RESET;
      // [RULE11] low count reset
      std_scl_low_count    <= icd_pkg::SCL_LOW_RESET;
      rx_hold              <= 8'h00;
      reg_rdata            <= 32'h00000000;
      cmd_valid            <= 1'b0;
      cmd_entry            <= '0;
      transmit_abort_event <= 1'b0;
      rx_pop               <= 1'b0;
    end else if (ce) begin
      if (wr_high) begin
        std_scl_high_count <= next_high;
      end
      if (wr_low) begin
        std_scl_low_count <= next_low;
      end
      if (rx_valid) begin
        rx_hold <= rx_byte;
      end
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
      rx_pop               <= reg_rd && sel_cmd;
      cmd_valid            <= do_push;
      transmit_abort_event <= do_abort;
      if (do_push) begin
        cmd_entry <= '{dir: is_read, data: push_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SCL phase generator: each phase lasts its count in mclk cycles.
  icd_pkg::icd_phase_t phase;     // Current SCL phase.
  logic [15:0]         phase_cnt; // Cycles spent in the phase.
  wire running = controller_enable && master_mode && scl_run;
  wire [15:0] phase_len = (phase == icd_pkg::PH_HIGH) ?
                          std_scl_high_count : std_scl_low_count;
  wire phase_done = phase_cnt >= phase_len - 16'h0001;

  // [RULE17] count phase cycles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase     <= icd_pkg::PH_HIGH;
      phase_cnt <= 16'h0000;
      scl_out   <= 1'b1;
      scl_oe    <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        // Idle: release the line and restart on a fresh high phase.
        phase     <= icd_pkg::PH_HIGH;
        phase_cnt <= 16'h0000;
        scl_out   <= 1'b1;
        scl_oe    <= 1'b0;
      end else if (phase_done) begin
        phase_cnt <= 16'h0000;
        case (phase)
          icd_pkg::PH_HIGH: begin
            phase   <= icd_pkg::PH_LOW;
            scl_out <= 1'b0;
            scl_oe  <= 1'b1;
          end
          default: begin
            phase   <= icd_pkg::PH_HIGH;
            scl_out <= 1'b1;
            scl_oe  <= 1'b0;
          end
        endcase
      end else begin
        phase_cnt <= phase_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus idle detection. The counter is only 16 bits wide, which is why the
  // high count must stay at or below its safe maximum: the target would
  // otherwise wrap to a small value and idle would be flagged too early.
  logic [15:0] idle_cnt; // Cycles with both lines high.
  wire [16:0] idle_sum    = {1'b0, std_scl_high_count} + icd_pkg::IDLE_MARGIN;
  wire [15:0] idle_target = idle_sum[15:0];
  wire        idle_hit    = idle_cnt == idle_target;

  // [RULE15] idle at high plus ten
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 16'h0000;
      bus_idle <= 1'b0;
    end else if (ce) begin
      if (!(scl_in && sda_in)) begin
        idle_cnt <= 16'h0000;
        bus_idle <= 1'b0;
      end else if (idle_hit) begin
        bus_idle <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_high_min;
    std_scl_high_count >= icd_pkg::SCL_HIGH_MIN;
  endproperty
  a_high_min: assert property (p_high_min) // [RULE13]
    else $error("high count below minimum");

  property p_low_min;
    std_scl_low_count >= icd_pkg::SCL_LOW_MIN;
  endproperty
  a_low_min: assert property (p_low_min) // [RULE14]
    else $error("low count below minimum");

  property p_locked;
    ce && controller_enable |=> $stable(std_scl_high_count) &&
                                $stable(std_scl_low_count);
  endproperty
  a_locked: assert property (p_locked) // [RULE12]
    else $error("count changed while enabled");

  property p_gc_abort;
    ce && wr_cmd && master_mode && reg_wdata[8] && general_call_sent &&
      command_flag_a |=> transmit_abort_event && !cmd_valid;
  endproperty
  a_gc_abort: assert property (p_gc_abort) // [RULE5]
    else $error("general call read not aborted");

  property p_rq_abort;
    ce && wr_cmd && !master_mode && slave_tx_mode && rd_req_seen &&
      reg_wdata[8] |=> transmit_abort_event;
  endproperty
  a_rq_abort: assert property (p_rq_abort) // [RULE6]
    else $error("read request abort missing");

  property p_read_cmd;
    cmd_valid && cmd_entry.dir |-> cmd_entry.data == 8'h00;
  endproperty
  a_read_cmd: assert property (p_read_cmd) // [RULE7]
    else $error("read command carried data");

  property p_write_cmd;
    ce && wr_cmd && master_mode && !reg_wdata[8] |=>
      cmd_valid && !cmd_entry.dir && cmd_entry.data == $past(reg_wdata[7:0]);
  endproperty
  a_write_cmd: assert property (p_write_cmd) // [RULE1]
    else $error("write command not pushed");

  property p_rx_read;
    ce && reg_rd && sel_cmd |=> reg_rdata == {24'h000000, $past(rx_hold)};
  endproperty
  a_rx_read: assert property (p_rx_read) // [RULE8]
    else $error("port read lost received byte");

  property p_idle;
    $rose(bus_idle) |-> idle_cnt == idle_target;
  endproperty
  a_idle: assert property (p_idle) // [RULE15]
    else $error("idle flagged at wrong count");

  c_push:  cover property (cmd_valid);
  c_abort: cover property (transmit_abort_event);
  c_scl:   cover property ($fell(scl_out));
  c_idle:  cover property ($rose(bus_idle));

endmodule // icd_top

// ---- logic/icd_pkg.sv ----
// Shared constants and types of the command port and SCL timing block.
package icd_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register map: byte addresses on the register port.
  localparam logic [7:0] CMD_DATA_OFFSET  = 8'h10; // Command/data port.
  localparam logic [7:0] SCL_HIGH_OFFSET  = 8'h14; // Standard high count.
  localparam logic [7:0] SCL_LOW_OFFSET   = 8'h18; // Standard low count.

  //////////////////////////////////////////////////////////////////////////
  // Field positions of the command/data port.
  localparam int DIR_BIT      = 8;  // Direction bit: 0 write, 1 read.
  localparam int BYTE_LSB     = 0;  // Lowest bit of the byte field.
  localparam int BYTE_W       = 8;  // Width of the byte field.
  localparam int COUNT_W      = 16; // Width of each SCL count field.

  // Direction encodings.
  localparam logic DIR_WRITE  = 1'h0; // Master write command.
  localparam logic DIR_READ   = 1'h1; // Master read command.

  //////////////////////////////////////////////////////////////////////////
  // Reset values and limits of the SCL counts.
  localparam logic [15:0] SCL_HIGH_RESET = 16'h0028; // High count reset.
  localparam logic [15:0] SCL_LOW_RESET  = 16'h002F; // Low count reset.
  localparam logic [15:0] SCL_HIGH_MIN   = 16'h0006; // Least high count.
  localparam logic [15:0] SCL_LOW_MIN    = 16'h0008; // Least low count.
  localparam logic [16:0] IDLE_MARGIN    = 17'h0000A; // Idle beyond high.
  localparam logic [15:0] SCL_HIGH_MAX   = 16'hFFF5; // Largest safe high.

  // One queued command: direction and byte.
  typedef struct packed {
    logic       dir;  // Read when set, write when clear.
    logic [7:0] data; // Byte to send; zero for reads.
  } icd_cmd_t;

  // Phase of the generated SCL.
  typedef enum logic {PH_HIGH, PH_LOW} icd_phase_t;

endpackage : icd_pkg

// ---- verif/icd_bus_model.sv ----
// Far-side model of the two bus lines: pull-ups and one holding device.
module icd_bus_model (
  input  wire logic scl_oe,   // Controller pulls SCL low.
  input  wire logic hold_sda, // A far device holds SDA low.
  output logic      scl_in,   // Wired level of SCL.
  output logic      sda_in    // Wired level of SDA.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open drain: a released line reads high through its pull-up.
  assign scl_in = !scl_oe;
  assign sda_in = !hold_sda;
endmodule // icd_bus_model

// ---- verif/icd_top_tb.sv ----
// Self-checking bench of the command port and SCL timing block.
module icd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, reg_wr, reg_rd, en, mst, stx, gcs, flag_a, rd_req;
  logic rx_valid, scl_run, scl_in, sda_in, hold_sda, scl_out, scl_oe;
  logic bus_idle, cmd_valid, abort, rx_pop, s_valid, s_abort, s_pop, ce;
  logic [7:0]        reg_addr, rx_byte, rb;
  logic [31:0]       reg_wdata, reg_rdata;
  icd_pkg::icd_cmd_t cmd_entry, s_entry;
  int err_total, samples_checked, seed, hi, lo, v, n, nh, nl;
  int exp_q[$]; // Expected pushed entries, oldest first.

  icd_top uut (.mclk(mclk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .controller_enable(en), .master_mode(mst),
    .slave_tx_mode(stx), .general_call_sent(gcs), .command_flag_a(flag_a),
    .rd_req_seen(rd_req), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .scl_run(scl_run), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .bus_idle(bus_idle),
    .cmd_valid(cmd_valid), .cmd_entry(cmd_entry),
    .transmit_abort_event(abort), .rx_pop(rx_pop));
  icd_bus_model bus_m (.scl_oe(scl_oe), .hold_sda(hold_sda),
    .scl_in(scl_in), .sda_in(sda_in));

  ////////////////////////////////////////////////////////////////////////////
  // A 100 ns clock.
  initial begin
    mclk = 0;
    forever #50 mclk = !mclk;
  end

  // Compares one value; four-state inequality lets no unknown pass.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One register access from a falling edge; pulses are caught the cycle
  // after, and an idle cycle follows so strobes never toggle in one step.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    // one whole word, so both count bytes land together
    reg_wr = w; reg_rd = !w; reg_addr = a; reg_wdata = d;
    @(posedge mclk);
    @(negedge mclk);
    s_valid = cmd_valid; s_entry = cmd_entry; s_abort = abort;
    s_pop = rx_pop;
    reg_wr = 0; reg_rd = 0;
    @(negedge mclk);
  endtask

  // Reads a register and compares it with the model.
  task automatic rd(input logic [7:0] a, input int exp);
    bus(0, a, 32'h0);
    check(reg_rdata, 32'(exp));
    check(32'(s_pop), 32'(a == icd_pkg::CMD_DATA_OFFSET)); // pop
  endtask

  // Pushes one command in a given mode; the model predicts the outcome.
  task automatic cmd(input logic m, s, g, f, q, dir);
    logic xa, xp;
    mst = m; stx = s; gcs = g; flag_a = f; rd_req = q;
    rb = 8'($random(seed));
    bus(1, icd_pkg::CMD_DATA_OFFSET, {23'h0, dir, rb});
    xa = dir & ((m & g & f) | (!m & s & q));
    xp = !xa & (m | s);
    if (xp) exp_q.push_back({23'h0, dir & m, (dir & m) ? 8'h0 : rb});
    check(32'(s_abort), 32'(xa));
    check(32'(s_valid), 32'(xp));
    if (xp) check(32'(s_entry), 32'(exp_q.pop_front()));
  endtask

  // Counts falling edges while SCL stays at one level.
  task automatic phase(input logic lvl, output int k);
    k = 0;
    while (scl_out !== lvl && k < 300) begin @(negedge mclk); k++; end
    k = 0;
    while (scl_out === lvl && k < 300) begin @(negedge mclk); k++; end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; every input changes on the falling edge.
  initial begin
    {reg_wr, reg_rd, en, mst, stx, gcs, flag_a, rd_req} = '0;
    {rx_valid, scl_run, hold_sda, reg_addr, rx_byte, reg_wdata} = '0;
    err_total = 0; samples_checked = 0; seed = 32'h5d0b2fad;
    ce = 1;
    resetn = 0; hi = 16'h0028; lo = 16'h002F;
    repeat (16) @(negedge mclk);
    resetn = 1;
    @(negedge mclk);
    rd(icd_pkg::SCL_HIGH_OFFSET, hi); // high reset
    rd(icd_pkg::SCL_LOW_OFFSET, lo); // low reset
    // random high count kept at or below the safe limit
    v = int'($random(seed) & 32'hFFFF) % 65525;
    bus(1, icd_pkg::SCL_HIGH_OFFSET, 32'(v));
    hi = (v < 6) ? 6 : v;
    rd(icd_pkg::SCL_HIGH_OFFSET, hi); // stored value
    en = 1;
    bus(1, icd_pkg::SCL_HIGH_OFFSET, 32'h0100);
    bus(1, icd_pkg::SCL_LOW_OFFSET, 32'h0100);
    rd(icd_pkg::SCL_HIGH_OFFSET, hi); // write while on dropped
    rd(icd_pkg::SCL_LOW_OFFSET, lo); // write while on dropped
    en = 0;
    // A frozen block must ignore an otherwise legal count write.
    ce = 0;
    bus(1, icd_pkg::SCL_LOW_OFFSET, 32'h0040);
    ce = 1;
    rd(icd_pkg::SCL_LOW_OFFSET, lo); // frozen write dropped
    bus(1, icd_pkg::SCL_HIGH_OFFSET, 32'h0003);
    bus(1, icd_pkg::SCL_LOW_OFFSET, 32'h0005);
    hi = 6; lo = 8;
    rd(icd_pkg::SCL_HIGH_OFFSET, hi); // clamp to six
    rd(icd_pkg::SCL_LOW_OFFSET, lo); // clamp to eight
    rd(8'h3C, 0); // unmapped address reads zero
    $display("test counts done");
    cmd(1, 0, 0, 0, 0, 0); // master write
    cmd(1, 0, 0, 1, 0, 1); // read drops byte
    cmd(1, 0, 1, 1, 0, 1); // abort after general call
    cmd(1, 0, 1, 0, 0, 1); // flag clear, no abort
    cmd(0, 1, 0, 0, 0, 0); // slave sends byte
    cmd(0, 1, 0, 0, 1, 1); // read after request aborts
    cmd(0, 0, 0, 0, 0, 1); // slave receiver drops entry
    rx_byte = 8'($random(seed)); rx_valid = 1;
    @(negedge mclk);
    rx_valid = 0;
    rd(icd_pkg::CMD_DATA_OFFSET, int'(rx_byte)); // received byte
    $display("test commands done");
    en = 1; mst = 1; scl_run = 1;
    phase(0, n);
    phase(1, nh);
    check(32'(scl_oe), 32'h1); // low phase pulls SCL
    phase(0, nl);
    check(32'(scl_oe), 32'h0); // high phase releases SCL
    check(32'(nh), 32'(hi)); // high phase
    check(32'(nl), 32'(lo)); // low phase
    scl_run = 0; en = 0; hold_sda = 1;
    repeat (3) @(negedge mclk);
    hold_sda = 0;
    n = 0;
    while (bus_idle !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
    check(32'(n >= hi + 10 && n <= hi + 12), 32'h1); // idle time
    $display("test scl and idle done");
    print_verdict();
  end

  // Cuts a hang short well beyond the hundred or so cycles the tests take.
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
endmodule // icd_top_tb
